/* File: verilog/vip_defines.svh */
/*
 vip_defines.svh: register offsets, field positions, reset values, sense codes,
 vector numbers and entry timing for the vectored interrupt prioritizer.
 Assumes an 8-bit register port with 8-bit offsets.
*/
`ifndef VIP_DEFINES_SVH
`define VIP_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define VIP_REG_CPU_CTRL 8'h35
`define VIP_REG_TIMER_FLAGS 8'h38
`define VIP_REG_TIMER_MASK 8'h39
`define VIP_REG_PIN_FLAGS 8'h3A
`define VIP_REG_PIN_MASK 8'h3B
`define VIP_REG_STATUS 8'h3F

// ----------------------------------------
// field positions and implemented bits
// ----------------------------------------
`define VIP_PIN_ZERO_BIT 6
`define VIP_PIN_ONE_BIT 7
`define VIP_PIN_BITS 8'hC0
`define VIP_T1_OVF_BIT 7
`define VIP_MATCH_A_BIT 6
`define VIP_MATCH_B_BIT 5
`define VIP_CAPTURE_BIT 3
`define VIP_T0_OVF_BIT 1
`define VIP_TIMER_BITS 8'hEA
`define VIP_CTRL_BITS 8'h0F
`define VIP_GIE_BIT 7

// ----------------------------------------
// reset values
// ----------------------------------------
`define VIP_RST_BYTE 8'h00
`define VIP_RST_FLAGS 2'h0

// ----------------------------------------
// sense-control codes
// ----------------------------------------
`define VIP_SENSE_LEVEL 2'h0
`define VIP_SENSE_FALL 2'h2
`define VIP_SENSE_RISE 2'h3

// ----------------------------------------
// vector numbers
// ----------------------------------------
`define VIP_VEC_RESET 4'h0
`define VIP_VEC_EXT0 4'h1
`define VIP_VEC_EXT1 4'h2
`define VIP_VEC_CAPTURE 4'h3
`define VIP_VEC_MATCH_A 4'h4
`define VIP_VEC_MATCH_B 4'h5
`define VIP_VEC_T1_OVF 4'h6
`define VIP_VEC_T0_OVF 4'h7
`define VIP_VEC_LAST 4'hC

// ----------------------------------------
// entry timing in clock cycles
// ----------------------------------------
`define VIP_ENTRY_LAST 2'h3
`define VIP_ENTRY_CYCLES 4
`define VIP_PUSH_CYCLES 2

`endif

/* File: verilog/vip_pkg.sv */
/*
 vip_pkg.sv: types of the vectored interrupt prioritizer.
 Assumes vip_defines.svh carries all numbers.
*/
package vip_pkg;

	// ----------------------------------------
	// controller states
	// ----------------------------------------
	typedef enum logic [2:0] {
		S_RST = 3'b001,
		S_IDLE = 3'b010,
		S_ENTRY = 3'b100
	} state_t;

	typedef logic [3:0] vector_t;

endpackage : vip_pkg

/* File: verilog/vectored_interrupt_prioritizer.sv */
/*
 vectored_interrupt_prioritizer.sv: pending flags, masks, sense control,
 global enable and priority selection of twelve interrupts plus reset.
 Assumes the core raises core_boundary between instructions, pulses
 core_retire per finished instruction and core_reti on return.
*/
// Added by the designer: strobed register access.
// Contract
// - twelve interrupts plus reset, each own vector
// - request needs own enable and global enable; periph_req lines enter with no own enable here
// - lower vector wins, reset highest
// - vector numbers fixed zero through twelve
// - flags set even while source disabled
// - pending flags served in priority order later
// - writing one clears flag, zero keeps
// - level external request has no flag
// - pin mask bits seven, six; rest zero
// - sense bits pick rising, falling or level
// - pin activity triggers even as output
// - pin flags bits seven, six set by edges
// - take vector, clear edge flag on entry
// - edge flag held clear in level mode
// - timer mask layout, reserved zero, reset zero
// - timer1 overflow goes to vector six
// - compare A goes to vector four
// - compare B goes to vector five
// - capture event goes to vector three
// - timer0 overflow goes to vector seven
// - entry four cycles, two pushes
// - wait for instruction boundary before taking
// - one instruction after return before next
`timescale 1ns/100ps
`default_nettype none
`include "vip_defines.svh"

module vectored_interrupt_prioritizer (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// external pins
	input wire logic [1:0] ext_pin,
	// timer events
	input wire logic t1_overflow_evt,
	input wire logic t1_match_a_evt,
	input wire logic t1_match_b_evt,
	input wire logic capture_evt,
	input wire logic t0_overflow_evt,
	// peripheral requests
	input wire logic [4:0] periph_req,
	// core handshake
	input wire logic core_boundary,
	input wire logic core_retire,
	input wire logic core_reti,
	output logic entry_busy,
	output logic stack_push,
	output logic vector_valid,
	output logic [3:0] vector,
	output logic global_enable
);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	vip_pkg::state_t state_q;
	logic [1:0] cnt_q;
	logic [7:0] ctrl_q;
	logic [7:0] tmask_q;
	logic [7:0] pmask_q;
	logic [7:0] tflag_q;
	logic [7:0] tflag_d;
	logic [1:0] ext_flag_q;
	logic [1:0] sync_a_q;
	logic [1:0] sync_b_q;
	logic [1:0] prev_q;
	logic gie_q;
	logic gie_d;
	logic hold_q;
	logic busy_q;
	logic push_q;
	logic valid_q;
	vip_pkg::vector_t vec_q;
	logic [7:0] rdata_q;

	// ----------------------------------------
	// register decode
	// ----------------------------------------
	wire wr_ctrl = reg_wr && (reg_addr == `VIP_REG_CPU_CTRL);
	wire wr_tflag = reg_wr && (reg_addr == `VIP_REG_TIMER_FLAGS);
	wire wr_tmask = reg_wr && (reg_addr == `VIP_REG_TIMER_MASK);
	wire wr_pflag = reg_wr && (reg_addr == `VIP_REG_PIN_FLAGS);
	wire wr_pmask = reg_wr && (reg_addr == `VIP_REG_PIN_MASK);
	wire wr_status = reg_wr && (reg_addr == `VIP_REG_STATUS);

	// ----------------------------------------
	// request gathering and priority
	// ----------------------------------------
	logic [1:0] ext_req;
	logic [1:0] ext_level;
	logic [12:0] req;
	wire accept;
	wire vip_pkg::vector_t win;

	function automatic vip_pkg::vector_t lowest(input logic [12:0] r);
		vip_pkg::vector_t w;
		w = `VIP_VEC_RESET;
		for (int i = 12; i >= 1; i--) begin
			if (r[i]) begin
				w = 4'(i);
			end
		end
		return w;
	endfunction : lowest

	assign req[0] = 1'b0;
	assign req[`VIP_VEC_EXT0] = pmask_q[`VIP_PIN_ZERO_BIT] && ext_req[0];
	assign req[`VIP_VEC_EXT1] = pmask_q[`VIP_PIN_ONE_BIT] && ext_req[1];
	assign req[`VIP_VEC_CAPTURE] = tmask_q[`VIP_CAPTURE_BIT] && tflag_q[`VIP_CAPTURE_BIT];
	assign req[`VIP_VEC_MATCH_A] = tmask_q[`VIP_MATCH_A_BIT] && tflag_q[`VIP_MATCH_A_BIT];
	assign req[`VIP_VEC_MATCH_B] = tmask_q[`VIP_MATCH_B_BIT] && tflag_q[`VIP_MATCH_B_BIT];
	assign req[`VIP_VEC_T1_OVF] = tmask_q[`VIP_T1_OVF_BIT] && tflag_q[`VIP_T1_OVF_BIT];
	assign req[`VIP_VEC_T0_OVF] = tmask_q[`VIP_T0_OVF_BIT] && tflag_q[`VIP_T0_OVF_BIT];
	assign req[`VIP_VEC_LAST:8] = periph_req;

	assign win = lowest(req);
	assign accept = (state_q == vip_pkg::S_IDLE) && gie_q && (|req) && core_boundary && !hold_q;

	// ----------------------------------------
	// external pins: sync, sense, edge flags
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_pin
			wire [1:0] sense = ctrl_q[2*g+1:2*g];
			wire rise = sync_b_q[g] && !prev_q[g];
			wire fall = !sync_b_q[g] && prev_q[g];
			wire hit = ((sense == `VIP_SENSE_RISE) && rise) || ((sense == `VIP_SENSE_FALL) && fall);
			wire clr = wr_pflag && reg_wdata[`VIP_PIN_ZERO_BIT+g];
			wire ack = accept && (win == (`VIP_VEC_EXT0 + 4'(g)));
			assign ext_level[g] = (sense == `VIP_SENSE_LEVEL);
			assign ext_req[g] = ext_level[g] ? !sync_b_q[g] : ext_flag_q[g];
			always_ff @(posedge clock or negedge arst_n) begin
				if (!arst_n) begin
					sync_a_q[g] <= 1'b1;
					sync_b_q[g] <= 1'b1;
					prev_q[g] <= 1'b1;
					ext_flag_q[g] <= 1'b0;
				end else begin
					sync_a_q[g] <= ext_pin[g];
					sync_b_q[g] <= sync_a_q[g];
					prev_q[g] <= sync_b_q[g];
					ext_flag_q[g] <= !ext_level[g] && (hit || (ext_flag_q[g] && !clr && !ack));
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// timer flags
	// ----------------------------------------
	wire [7:0] tevt = {t1_overflow_evt, t1_match_a_evt, t1_match_b_evt, 1'b0, capture_evt, 1'b0, t0_overflow_evt, 1'b0};
	wire [7:0] tack = {accept && (win == `VIP_VEC_T1_OVF), accept && (win == `VIP_VEC_MATCH_A),
		accept && (win == `VIP_VEC_MATCH_B), 1'b0, accept && (win == `VIP_VEC_CAPTURE), 1'b0,
		accept && (win == `VIP_VEC_T0_OVF), 1'b0};
	wire [7:0] tclr = wr_tflag ? reg_wdata : `VIP_RST_BYTE;
	assign tflag_d = (tevt | (tflag_q & ~tclr & ~tack)) & `VIP_TIMER_BITS;

	// ----------------------------------------
	// global enable
	// ----------------------------------------
	assign gie_d = accept ? 1'b0 : core_reti ? 1'b1 : wr_status ? reg_wdata[`VIP_GIE_BIT] : gie_q;

	// ----------------------------------------
	// register file and read port
	// ----------------------------------------
	wire [7:0] rd_mux =
		(reg_addr == `VIP_REG_CPU_CTRL) ? ctrl_q :
		(reg_addr == `VIP_REG_TIMER_FLAGS) ? tflag_q :
		(reg_addr == `VIP_REG_TIMER_MASK) ? tmask_q :
		(reg_addr == `VIP_REG_PIN_FLAGS) ? {ext_flag_q, 6'h00} :
		(reg_addr == `VIP_REG_PIN_MASK) ? pmask_q :
		(reg_addr == `VIP_REG_STATUS) ? {gie_q, 7'h00} : `VIP_RST_BYTE;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q <= `VIP_RST_BYTE;
			tmask_q <= `VIP_RST_BYTE;
			pmask_q <= `VIP_RST_BYTE;
			tflag_q <= `VIP_RST_BYTE;
			gie_q <= 1'b0;
			hold_q <= 1'b0;
			rdata_q <= `VIP_RST_BYTE;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= reg_wdata & `VIP_CTRL_BITS;
			end
			if (wr_tmask) begin
				tmask_q <= reg_wdata & `VIP_TIMER_BITS;
			end
			if (wr_pmask) begin
				pmask_q <= reg_wdata & `VIP_PIN_BITS;
			end
			tflag_q <= tflag_d;
			gie_q <= gie_d;
			hold_q <= core_reti || (hold_q && !core_retire);
			rdata_q <= reg_rd ? rd_mux : `VIP_RST_BYTE;
		end
	end

	// ----------------------------------------
	// entry sequencer
	// ----------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= vip_pkg::S_RST;
			cnt_q <= 2'h0;
			busy_q <= 1'b0;
			push_q <= 1'b0;
			valid_q <= 1'b0;
			vec_q <= `VIP_VEC_RESET;
		end else begin
			unique case (state_q)
				vip_pkg::S_RST: begin
					valid_q <= 1'b1;
					vec_q <= `VIP_VEC_RESET;
					state_q <= vip_pkg::S_IDLE;
				end
				vip_pkg::S_IDLE: begin
					valid_q <= 1'b0;
					if (accept) begin
						state_q <= vip_pkg::S_ENTRY;
						cnt_q <= 2'h0;
						busy_q <= 1'b1;
						push_q <= 1'b1;
						vec_q <= win;
					end
				end
				vip_pkg::S_ENTRY: begin
					cnt_q <= cnt_q + 2'h1;
					push_q <= (cnt_q == 2'h0);
					if (cnt_q == `VIP_ENTRY_LAST) begin
						state_q <= vip_pkg::S_IDLE;
						busy_q <= 1'b0;
						valid_q <= 1'b1;
					end
				end
				default: begin
					state_q <= vip_pkg::S_IDLE;
				end
			endcase
		end
	end

	assign reg_rdata = rdata_q;
	assign entry_busy = busy_q;
	assign stack_push = push_q;
	assign vector_valid = valid_q;
	assign vector = vec_q;
	assign global_enable = gie_q;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_gate_enable;
		@(posedge clock) disable iff (!arst_n) accept |-> gie_q && req[win] && !hold_q && core_boundary;
	endproperty
	a_gate_enable: assert property (p_gate_enable) else $error("accept without enables");

	property p_prio;
		@(posedge clock) disable iff (!arst_n) accept && req[`VIP_VEC_EXT0] |=> vec_q == `VIP_VEC_EXT0;
	endproperty
	a_prio: assert property (p_prio) else $error("ext0 not first");

	property p_lower_pends;
		@(posedge clock) disable iff (!arst_n)
			accept && req[`VIP_VEC_T1_OVF] && req[`VIP_VEC_T0_OVF] && !tevt[`VIP_T0_OVF_BIT]
			|=> tflag_q[`VIP_T0_OVF_BIT];
	endproperty
	a_lower_pends: assert property (p_lower_pends) else $error("lower request lost");

	property p_entry;
		@(posedge clock) disable iff (!arst_n) accept |=> (!valid_q && busy_q) [*4] ##1 valid_q && !busy_q;
	endproperty
	a_entry: assert property (p_entry) else $error("entry length wrong");

	property p_push;
		@(posedge clock) disable iff (!arst_n) accept |=> push_q [*2] ##1 !push_q [*2];
	endproperty
	a_push: assert property (p_push) else $error("push count wrong");

	property p_gie_off;
		@(posedge clock) disable iff (!arst_n) accept |=> !gie_q;
	endproperty
	a_gie_off: assert property (p_gie_off) else $error("global enable kept");

	property p_level_clear;
		@(posedge clock) disable iff (!arst_n) ext_level[0] |=> !ext_flag_q[0];
	endproperty
	a_level_clear: assert property (p_level_clear) else $error("flag in level mode");

	property p_edge_set;
		@(posedge clock) disable iff (!arst_n)
			ctrl_q[1:0] == `VIP_SENSE_FALL && prev_q[0] && !sync_b_q[0] |=> ext_flag_q[0];
	endproperty
	a_edge_set: assert property (p_edge_set) else $error("falling edge missed");

	property p_write_zero;
		@(posedge clock) disable iff (!arst_n)
			wr_tflag && !reg_wdata[`VIP_T1_OVF_BIT] && tflag_q[`VIP_T1_OVF_BIT] && !tack[`VIP_T1_OVF_BIT]
			|=> tflag_q[`VIP_T1_OVF_BIT];
	endproperty
	a_write_zero: assert property (p_write_zero) else $error("zero write cleared");

	property p_hold;
		@(posedge clock) disable iff (!arst_n) core_reti ##1 !core_retire |-> !accept;
	endproperty
	a_hold: assert property (p_hold) else $error("taken before one instruction");

	property p_mask_read;
		@(posedge clock) disable iff (!arst_n) reg_rd && reg_addr == `VIP_REG_PIN_MASK |=> reg_rdata[5:0] == 6'h00;
	endproperty
	a_mask_read: assert property (p_mask_read) else $error("reserved bits set");

	property p_flag_set;
		@(posedge clock) disable iff (!arst_n) t1_match_a_evt |=> tflag_q[`VIP_MATCH_A_BIT];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("disabled source flag lost");

	property p_pending_kept;
		@(posedge clock) disable iff (!arst_n)
			!gie_q && tflag_q[`VIP_CAPTURE_BIT] && !(wr_tflag && reg_wdata[`VIP_CAPTURE_BIT]) |=> tflag_q[`VIP_CAPTURE_BIT];
	endproperty
	a_pending_kept: assert property (p_pending_kept) else $error("pending flag dropped");

	property p_take_clear;
		@(posedge clock) disable iff (!arst_n) accept && win == `VIP_VEC_EXT1 && !g_pin[1].hit |=> !ext_flag_q[1];
	endproperty
	a_take_clear: assert property (p_take_clear) else $error("edge flag kept after take");

	property p_timer_clear;
		@(posedge clock) disable iff (!arst_n) accept && win == `VIP_VEC_T1_OVF && !t1_overflow_evt |=> !tflag_q[`VIP_T1_OVF_BIT];
	endproperty
	a_timer_clear: assert property (p_timer_clear) else $error("timer flag kept after take");

	property p_level_req;
		@(posedge clock) disable iff (!arst_n) ext_level[0] && pmask_q[`VIP_PIN_ZERO_BIT] && !sync_b_q[0] |-> req[`VIP_VEC_EXT0];
	endproperty
	a_level_req: assert property (p_level_req) else $error("low level without request");

	property p_timer_reserved;
		@(posedge clock) disable iff (!arst_n) reg_rd && reg_addr == `VIP_REG_TIMER_MASK |=> (reg_rdata & ~`VIP_TIMER_BITS) == `VIP_RST_BYTE;
	endproperty
	a_timer_reserved: assert property (p_timer_reserved) else $error("timer mask reserved bits set");

	property p_valid_pulse;
		@(posedge clock) disable iff (!arst_n) vector_valid |=> !vector_valid;
	endproperty
	a_valid_pulse: assert property (p_valid_pulse) else $error("vector strobe too long");

	property p_lowest_wins;
		@(posedge clock) disable iff (!arst_n) accept |-> (req & ((13'h1 << win) - 13'h1)) == 13'h0;
	endproperty
	a_lowest_wins: assert property (p_lowest_wins) else $error("higher priority request passed over");

	c_take: cover property (@(posedge clock) disable iff (!arst_n) accept ##5 valid_q);
	c_back: cover property (@(posedge clock) disable iff (!arst_n) accept ##[5:20] accept);
	c_reti: cover property (@(posedge clock) disable iff (!arst_n) core_reti ##[1:10] accept);
	c_level: cover property (@(posedge clock) disable iff (!arst_n) accept && win == `VIP_VEC_EXT0 && ext_level[0]);
	c_edge: cover property (@(posedge clock) disable iff (!arst_n) accept && win == `VIP_VEC_EXT1 && !ext_level[1]);

endmodule : vectored_interrupt_prioritizer

`default_nettype wire

/* File: bench/core_model.sv */
/*
 core_model.sv: processor core that runs a short handler for each vector taken.
 Assumes vector_valid is a one-cycle pulse and the reset vector needs no handler.
*/
`timescale 1ns/100ps
`default_nettype none

module core_model (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// prioritizer side
	input wire logic vector_valid,
	input wire logic [3:0] vector,
	output logic core_boundary,
	output logic core_retire,
	output logic core_reti,
	// bench control
	input wire logic stall
);
	// ----------------------------------------
	// handler sequencer
	// ----------------------------------------
	logic [3:0] step_q;
	logic [3:0] step_d;
	logic step_end;
	assign step_end = step_q == 4'h0 || step_q == 4'h8;
	assign step_d = (vector_valid && vector != 4'h0) ? 4'h1 : step_end ? 4'h0 : step_q + 4'h1;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			step_q <= 4'h0;
		end else begin
			step_q <= step_d;
		end
	end
	// stall models a multi-cycle instruction in progress
	assign core_boundary = !stall;
	// one main-program instruction retires after the return
	assign core_retire = (step_q != 4'h0 && step_q < 4'h4) || step_q == 4'h8;
	assign core_reti = step_q == 4'h6;
endmodule : core_model

`default_nettype wire

/* File: bench/vectored_interrupt_prioritizer_test.sv */
/*
 vectored_interrupt_prioritizer_test.sv: self-checking bench of the prioritizer.
 Assumes core_model answers on the core link and the bench plays the peripherals.
*/
`timescale 1ns/100ps
`default_nettype none
`include "vip_defines.svh"

module vectored_interrupt_prioritizer_test;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [1:0] ext_pin = 2'h3;
	logic [4:0] tev = 5'h00;
	logic [4:0] periph_req = 5'h00;
	logic stall = 1'b0;
	logic core_boundary, core_retire, core_reti;
	logic entry_busy, stack_push, vector_valid, global_enable;
	logic [3:0] vector;
	int fail_count = 0;
	int checks = 0;
	logic [3:0] tvec [5] = '{4'h6, 4'h4, 4'h5, 4'h3, 4'h7};

	vectored_interrupt_prioritizer dut_u (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_pin(ext_pin),
		.t1_overflow_evt(tev[0]), .t1_match_a_evt(tev[1]), .t1_match_b_evt(tev[2]), .capture_evt(tev[3]),
		.t0_overflow_evt(tev[4]), .periph_req(periph_req), .core_boundary(core_boundary),
		.core_retire(core_retire), .core_reti(core_reti), .entry_busy(entry_busy), .stack_push(stack_push),
		.vector_valid(vector_valid), .vector(vector), .global_enable(global_enable));
	core_model core_u (.clock(clock), .arst_n(arst_n), .vector_valid(vector_valid), .vector(vector),
		.core_boundary(core_boundary), .core_retire(core_retire), .core_reti(core_reti), .stall(stall));

	initial begin
		forever #2 clock = ~clock;
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(negedge clock);
		check($sformatf("register %h", a), reg_rdata, e);
	endtask : rchk

	task automatic pulse(input logic [4:0] ev);
		@(posedge clock);
		tev <= ev;
		@(posedge clock);
		tev <= 5'h00;
	endtask : pulse

	task automatic idle(input int n);
		repeat (n) @(negedge clock);
	endtask : idle

	task automatic wait_take(input logic [3:0] exp);
		int busy;
		int push;
		int n;
		busy = 0;
		push = 0;
		n = 0;
		while (vector_valid !== 1'b1 && n < 80) begin
			@(negedge clock);
			busy += int'(entry_busy === 1'b1);
			push += int'(stack_push === 1'b1);
			n++;
		end
		check("vector", {4'h0, vector}, {4'h0, exp});
		check("entry cycles", 8'(busy), 8'h04);
		check("pushes", 8'(push), 8'h02);
		check("global enable", {7'h00, global_enable}, 8'h00);
		@(negedge clock);
	endtask : wait_take

	task automatic no_take(input int n);
		int seen;
		seen = 0;
		repeat (n) begin
			@(negedge clock);
			seen += int'(vector_valid === 1'b1);
		end
		check("unexpected take", 8'(seen), 8'h00);
	endtask : no_take

	task automatic finish_test();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		idle(2);
		check("reset vector", {3'h0, vector_valid, vector}, 8'h10);
		rchk(`VIP_REG_TIMER_MASK, 8'h00);
		rchk(`VIP_REG_PIN_MASK, 8'h00);
		rchk(`VIP_REG_STATUS, 8'h00);
		wr(`VIP_REG_TIMER_MASK, 8'hFF);
		rchk(`VIP_REG_TIMER_MASK, 8'hEA);
		wr(`VIP_REG_PIN_MASK, 8'hFF);
		rchk(`VIP_REG_PIN_MASK, 8'hC0);
		wr(8'h20, 8'hFF);
		rchk(8'h20, 8'h00);
		wr(`VIP_REG_PIN_MASK, 8'h00);
		wr(`VIP_REG_TIMER_MASK, 8'h00);
	endtask : t_reset

	task automatic t_gate();
		wr(`VIP_REG_STATUS, 8'h80);
		pulse(5'h02);
		no_take(10);
		rchk(`VIP_REG_TIMER_FLAGS, 8'h40);
		wr(`VIP_REG_TIMER_MASK, 8'h40);
		wait_take(4'h4);
		idle(12);
		rchk(`VIP_REG_TIMER_FLAGS, 8'h00);
		rchk(`VIP_REG_STATUS, 8'h80);
		wr(`VIP_REG_TIMER_MASK, 8'h00);
		pulse(5'h02);
		wr(`VIP_REG_TIMER_FLAGS, 8'h00);
		rchk(`VIP_REG_TIMER_FLAGS, 8'h40);
		wr(`VIP_REG_TIMER_FLAGS, 8'h40);
		rchk(`VIP_REG_TIMER_FLAGS, 8'h00);
	endtask : t_gate

	task automatic t_prio();
		wr(`VIP_REG_STATUS, 8'h00);
		wr(`VIP_REG_TIMER_MASK, 8'hEA);
		pulse(5'h19);
		no_take(10);
		rchk(`VIP_REG_TIMER_FLAGS, 8'h8A);
		wr(`VIP_REG_STATUS, 8'h80);
		wait_take(4'h3);
		wait_take(4'h6);
		wait_take(4'h7);
		idle(12);
		rchk(`VIP_REG_TIMER_FLAGS, 8'h00);
	endtask : t_prio

	task automatic t_each();
		for (int i = 0; i < 5; i++) begin
			pulse(5'h01 << i);
			wait_take(tvec[i]);
		end
		for (int i = 0; i < 5; i++) begin
			@(posedge clock);
			periph_req <= 5'h01 << i;
			wait_take(4'h8 + 4'(i));
			@(posedge clock);
			periph_req <= 5'h00;
		end
		idle(12);
		@(posedge clock);
		stall <= 1'b1;
		pulse(5'h02);
		no_take(10);
		@(posedge clock);
		stall <= 1'b0;
		wait_take(4'h4);
		idle(12);
	endtask : t_each

	task automatic t_pin();
		wr(`VIP_REG_TIMER_MASK, 8'h00);
		wr(`VIP_REG_CPU_CTRL, 8'h02);
		@(posedge clock);
		ext_pin[0] <= 1'b0;
		idle(6);
		rchk(`VIP_REG_PIN_FLAGS, 8'h40);
		wr(`VIP_REG_PIN_FLAGS, 8'h40);
		rchk(`VIP_REG_PIN_FLAGS, 8'h00);
		wr(`VIP_REG_CPU_CTRL, 8'h0C);
		@(posedge clock);
		ext_pin[1] <= 1'b0;
		idle(6);
		@(posedge clock);
		ext_pin[1] <= 1'b1;
		idle(6);
		rchk(`VIP_REG_PIN_FLAGS, 8'h80);
		wr(`VIP_REG_PIN_MASK, 8'hC0);
		wait_take(4'h1);
		@(posedge clock);
		ext_pin[0] <= 1'b1;
		wait_take(4'h2);
		idle(12);
		rchk(`VIP_REG_PIN_FLAGS, 8'h00);
		no_take(10);
		wr(`VIP_REG_CPU_CTRL, 8'h05);
		@(posedge clock);
		ext_pin[0] <= 1'b0;
		no_take(10);
		rchk(`VIP_REG_PIN_FLAGS, 8'h00);
	endtask : t_pin

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge clock);
		arst_n <= 1'b1;
		t_reset();
		t_gate();
		t_prio();
		t_each();
		t_pin();
		finish_test();
	end

	initial begin
		repeat (20000) @(posedge clock);
		fail_count++;
		finish_test();
	end
endmodule : vectored_interrupt_prioritizer_test

`default_nettype wire
